// [rtl/pwr_pkg.sv]
// Purpose: Shared constants and types for the power-mode and wake-up controller
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Flag bit positions mirror the peripheral status layouts
`default_nettype none
package pwr_pkg;
	// ==========================================================
	// Power states
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_IDLE,
		ST_PD_ENTER,
		ST_POWERDOWN,
		ST_OSC_RESTART,
		ST_CLK_RELEASE
	} pwr_state_e;

	// ==========================================================
	// Wake source indices
	localparam int SRC_RTC = 0;
	localparam int SRC_WDT = 1;
	localparam int SRC_TWI = 2;
	localparam int SRC_TMR = 3;
	localparam int SRC_UART = 4;
	localparam int SRC_UNIVERSAL_SERIAL_UNIT = 5;
	localparam int SRC_BOD = 6;
	localparam int SRC_VOLTAGE_DETECTOR = 7;
	localparam int SRC_GPIO = 8;
	localparam int SRC_ANALOG_COMPARATOR = 9;
	localparam int NUM_SRC = 10;

	// ==========================================================
	// Flag bit positions in the peripheral status words
	localparam int BOD_FLAG_BIT = 4;
	localparam int VOLTAGE_DETECTOR_FLAG_BIT = 19;
	localparam int TMR_IRQ_BIT = 0;
	localparam int TMR_WAKE_BIT = 1;
	localparam int WDT_WAKE_BIT = 5;
	localparam int RTC_ALARM_BIT = 0;
	localparam int RTC_TICK_BIT = 1;
	localparam int UART_FIRST_BIT = 0;
	localparam int UART_LAST_BIT = 4;
	localparam int UNIVERSAL_SERIAL_UNIT_WAKE_BIT = 0;
	localparam int UNIVERSAL_SERIAL_UNIT_ACK_BIT = 16;
	localparam int TWI_WAKE_BIT = 0;
	localparam int TWI_ACK_BIT = 1;
	localparam int ACMP0_BIT = 8;
	localparam int ACMP1_BIT = 9;

	// ==========================================================
	// Timing and reset values
	localparam int OSC_SETTLE_NS = 2000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [NUM_SRC-1:0] PEND_RESET = 10'h000;
endpackage
`default_nettype wire

// [rtl/pwr_gate_if.sv]
// Purpose: Bundle of clock-gate enables between the controller and its gate unit
// Assumes: Driven by the state register of the controller and, for the clock selects, straight from its input ports
// Notes: One modport per side
`default_nettype none
interface pwr_gate_if;
	logic in_idle;
	logic in_pd;
	logic lxt_sw_on;
	logic low_speed_internal_osc_sw_on;
	logic tmr_sel_low;
	logic wdt_sel_low_speed_internal_osc;
	logic rtc_sel_lxt;
	logic uart_sel_lxt;
	modport ctrl (output in_idle, in_pd, lxt_sw_on, low_speed_internal_osc_sw_on, tmr_sel_low, wdt_sel_low_speed_internal_osc,
		rtc_sel_lxt, uart_sel_lxt);
	modport gate (input in_idle, in_pd, lxt_sw_on, low_speed_internal_osc_sw_on, tmr_sel_low, wdt_sel_low_speed_internal_osc,
		rtc_sel_lxt, uart_sel_lxt);
endinterface
`default_nettype wire

// [rtl/pwr_clock_gates.sv]
// Purpose: Registered oscillator and clock enables per power state
// Assumes: Enables are sampled on every enabled clock edge
// Notes: All outputs come from flip-flops
`default_nettype none
module pwr_clock_gates (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	pwr_gate_if.gate g,
	output logic hxt_en,
	output logic internal_fast_osc_en,
	output logic internal_48m_osc_en,
	output logic pll_en,
	output logic lxt_en,
	output logic low_speed_internal_osc_en,
	output logic core_clk_en,
	output logic bus_clk_en,
	output logic flash_en,
	output logic periph_en,
	output logic ldo_en,
	output logic sram_ret_en,
	output logic timer_clk_en,
	output logic wdt_clk_en,
	output logic rtc_clk_en,
	output logic uart_clk_en
);
	typedef struct packed {
		logic [15:0] en;
	} gate_s;
	gate_s r, next_r;
	logic lxt_on, low_speed_internal_osc_on;

	// ==========================================================
	// Enable map
	always_comb begin
		lxt_on = ~g.in_pd | g.lxt_sw_on; // R6
		low_speed_internal_osc_on = ~g.in_pd | g.low_speed_internal_osc_sw_on; // R6
		next_r.en[0] = ~g.in_pd; // R5
		next_r.en[1] = ~g.in_pd; // R5
		next_r.en[2] = ~g.in_pd; // R5
		next_r.en[3] = ~g.in_pd; // R5
		next_r.en[4] = lxt_on;
		next_r.en[5] = low_speed_internal_osc_on;
		next_r.en[6] = ~g.in_idle & ~g.in_pd; // R3
		next_r.en[7] = ~g.in_pd; // R5
		next_r.en[8] = ~g.in_pd; // R5
		next_r.en[9] = ~g.in_pd; // R5
		next_r.en[10] = 1'b1; // R5
		next_r.en[11] = 1'b1; // R5
		// Timer keeps going when low-speed is selected and either low-speed source is running
		next_r.en[12] = ~g.in_pd | (g.tmr_sel_low & (lxt_on | low_speed_internal_osc_on)); // R7
		next_r.en[13] = ~g.in_pd | (g.wdt_sel_low_speed_internal_osc & low_speed_internal_osc_on); // R7
		next_r.en[14] = ~g.in_pd | (g.rtc_sel_lxt & lxt_on); // R8
		next_r.en[15] = ~g.in_pd | (g.uart_sel_lxt & lxt_on); // R8
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r.en <= 16'hFFFF; // R1
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign {uart_clk_en, rtc_clk_en, wdt_clk_en, timer_clk_en, sram_ret_en, ldo_en, periph_en,
		flash_en, bus_clk_en, core_clk_en, low_speed_internal_osc_en, lxt_en, pll_en, internal_48m_osc_en, internal_fast_osc_en,
		hxt_en} = r.en;
endmodule
`default_nettype wire

// [rtl/power_mode_wakeup_control.sv]
// Purpose: Power-mode controller moving the chip between normal, idle and power-down
// Assumes: Inputs synchronous to clk; peripheral flags arrive as levels
// Notes: Power-down re-entry waits for every wake flag of the waking source to clear
//
// What this block does
// R1 - After reset release the chip is in normal mode with all clocks running.
// R2 - Wait-for-interrupt without deep sleep request enters idle, core sleeps.
// R3 - Idle stops only the core clock; any interrupt wakes it.
// R4 - Power-down needs sleep enable and deep sleep request, then wait-for-interrupt.
// R5 - Power-down halts fast oscillators, PLL, bus clocks, flash; keeps regulator, SRAM.
// R6 - Low-speed crystal and internal oscillator follow their normal-mode software setting.
// R7 - Timers run on live low-speed source; watchdog only on live internal oscillator.
// R8 - RTC and serial port run only on a live low-speed crystal.
// R9 - Power-down wakes only from the ten listed peripheral source groups.
// R10 - Any wake event from idle or power-down returns to normal mode.
// R11 - Software clears the waking source's flag before re-entering power-down.
// R12 - Brown-out flag bit 4 is write-one-clear; re-entry waits for it.
// R13 - Voltage-detector flag bit 19 is write-one-clear; re-entry waits for it.
// R14 - After a GPIO wake the pin source bit must clear before re-entry.
// R15 - Timer wake flag bit 1 and interrupt flag bit 0 both must clear.
// R16 - Watchdog wake flag bit 5 must clear before re-entry.
// R17 - RTC alarm bit 0 and tick bit 1 must both clear before re-entry.
// R18 - Serial wake flags bits 0 to 4 must clear before re-entry.
// R19 - Serial unit wake bit 0 clears; address-match ack bit 16 first.
// R20 - Two-wire ack-done bit 1 clears first, then wake flag bit 0.
// R21 - Comparator wake flags bits 8 and 9 must both clear.
// R22 - Power-down wake restarts oscillators and releases clocks before the core resumes; core_clk_en rises one cycle after core_resume.
`default_nettype none
module power_mode_wakeup_control #(
	parameter int GPIO_PINS = 16,
	parameter int SETTLE_CYC = pwr_pkg::OSC_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wfi,
	input wire logic sleep_en,
	input wire logic deep_sleep_request,
	input wire logic any_irq,
	input wire logic lxt_sw_on,
	input wire logic low_speed_internal_osc_sw_on,
	input wire logic tmr_sel_low,
	input wire logic wdt_sel_low_speed_internal_osc,
	input wire logic rtc_sel_lxt,
	input wire logic uart_sel_lxt,
	input wire logic [31:0] bod_ctl_flags,
	input wire logic [GPIO_PINS-1:0] pin_irq_source_bits,
	input wire logic [1:0] timer_status,
	input wire logic [7:0] wdt_ctl_flags,
	input wire logic [1:0] rtc_status,
	input wire logic [4:0] uart_wake_status,
	input wire logic [16:0] universal_serial_unit_status,
	input wire logic [1:0] twowire_wake_status,
	input wire logic [9:0] analog_comparator_status,
	output logic core_sleep,
	output logic core_resume,
	output logic in_idle,
	output logic in_powerdown,
	output logic reentry_blocked,
	output logic [pwr_pkg::NUM_SRC-1:0] wake_cause,
	output logic hxt_en,
	output logic internal_fast_osc_en,
	output logic internal_48m_osc_en,
	output logic pll_en,
	output logic lxt_en,
	output logic low_speed_internal_osc_en,
	output logic core_clk_en,
	output logic bus_clk_en,
	output logic flash_en,
	output logic periph_en,
	output logic ldo_en,
	output logic sram_ret_en,
	output logic timer_clk_en,
	output logic wdt_clk_en,
	output logic rtc_clk_en,
	output logic uart_clk_en
);
	// ==========================================================
	// State
	typedef struct packed {
		pwr_pkg::pwr_state_e st;
		logic [7:0] cnt;
		logic [pwr_pkg::NUM_SRC-1:0] pend;
		logic lxt_keep;
		logic low_speed_internal_osc_keep;
		logic resume;
		logic sleep;
		logic idle;
		logic pd;
		logic blocked;
	} ctl_s;
	ctl_s r, next_r;

	logic [pwr_pkg::NUM_SRC-1:0] src_flag;
	logic wake_any;
	logic flags_clear;
	logic universal_serial_unit_wake;
	logic twi_ack;
	logic twi_wake;
	logic universal_serial_unit_ack;

	pwr_gate_if gif();

	// ==========================================================
	// Wake source flags
	always_comb begin
		universal_serial_unit_ack = universal_serial_unit_status[pwr_pkg::UNIVERSAL_SERIAL_UNIT_ACK_BIT];
		universal_serial_unit_wake = universal_serial_unit_status[pwr_pkg::UNIVERSAL_SERIAL_UNIT_WAKE_BIT]; // R19
		twi_ack = twowire_wake_status[pwr_pkg::TWI_ACK_BIT];
		twi_wake = twowire_wake_status[pwr_pkg::TWI_WAKE_BIT]; // R20
		src_flag = '0;
		src_flag[pwr_pkg::SRC_BOD] = bod_ctl_flags[pwr_pkg::BOD_FLAG_BIT]; // R12
		src_flag[pwr_pkg::SRC_VOLTAGE_DETECTOR] = bod_ctl_flags[pwr_pkg::VOLTAGE_DETECTOR_FLAG_BIT]; // R13
		src_flag[pwr_pkg::SRC_GPIO] = |pin_irq_source_bits; // R14
		src_flag[pwr_pkg::SRC_TMR] = timer_status[pwr_pkg::TMR_WAKE_BIT]
			| timer_status[pwr_pkg::TMR_IRQ_BIT]; // R15
		src_flag[pwr_pkg::SRC_WDT] = wdt_ctl_flags[pwr_pkg::WDT_WAKE_BIT]; // R16
		src_flag[pwr_pkg::SRC_RTC] = rtc_status[pwr_pkg::RTC_ALARM_BIT]
			| rtc_status[pwr_pkg::RTC_TICK_BIT]; // R17
		src_flag[pwr_pkg::SRC_UART] =
			|uart_wake_status[pwr_pkg::UART_LAST_BIT:pwr_pkg::UART_FIRST_BIT]; // R18
		// Ack flag keeps the unit pending until it is cleared ahead of the wake flag
		src_flag[pwr_pkg::SRC_UNIVERSAL_SERIAL_UNIT] = universal_serial_unit_wake | universal_serial_unit_ack; // R19
		src_flag[pwr_pkg::SRC_TWI] = twi_wake | twi_ack; // R20
		src_flag[pwr_pkg::SRC_ANALOG_COMPARATOR] = analog_comparator_status[pwr_pkg::ACMP0_BIT]
			| analog_comparator_status[pwr_pkg::ACMP1_BIT]; // R21
		wake_any = |src_flag; // R9
		flags_clear = ~|(r.pend & src_flag); // R11
	end

	// ==========================================================
	// Mode sequencer
	always_comb begin
		next_r = r;
		next_r.resume = 1'b0;
		// Pending bits drop only once software has cleared the source flags
		next_r.pend = r.pend & src_flag; // R11
		case (r.st)
			pwr_pkg::ST_NORMAL: begin
				if (wfi) begin
					if (sleep_en && deep_sleep_request) begin
						if (flags_clear) begin // R11
							next_r.lxt_keep = lxt_sw_on; // R6
							next_r.low_speed_internal_osc_keep = low_speed_internal_osc_sw_on; // R6
							next_r.st = pwr_pkg::ST_PD_ENTER; // R4
						end
					end else if (!deep_sleep_request) begin
						next_r.st = pwr_pkg::ST_IDLE; // R2
					end
				end
			end
			pwr_pkg::ST_IDLE: begin
				if (any_irq || wake_any) begin
					next_r.st = pwr_pkg::ST_NORMAL; // R3
					next_r.resume = 1'b1; // R10
				end
			end
			pwr_pkg::ST_PD_ENTER: begin
				next_r.st = pwr_pkg::ST_POWERDOWN; // R5
			end
			pwr_pkg::ST_POWERDOWN: begin
				if (wake_any) begin // R9
					next_r.pend = src_flag;
					next_r.cnt = pwr_pkg::CNT_RESET;
					next_r.st = pwr_pkg::ST_OSC_RESTART; // R22
				end
			end
			pwr_pkg::ST_OSC_RESTART: begin
				// Oscillators get settling time before the core resumes; bus, flash and peripheral clock enables are already set here
				if (int'(r.cnt) >= SETTLE_CYC - 1) begin
					next_r.st = pwr_pkg::ST_CLK_RELEASE; // R22
				end else begin
					next_r.cnt = r.cnt + 8'h01;
				end
			end
			pwr_pkg::ST_CLK_RELEASE: begin
				next_r.st = pwr_pkg::ST_NORMAL; // R10
				next_r.resume = 1'b1; // R22
			end
			default: begin
				next_r.st = pwr_pkg::ST_NORMAL;
			end
		endcase
		// Status flags are registered copies of the next state, so outputs leave flops
		next_r.sleep = (next_r.st != pwr_pkg::ST_NORMAL);
		next_r.idle = (next_r.st == pwr_pkg::ST_IDLE);
		next_r.pd = (next_r.st == pwr_pkg::ST_POWERDOWN);
		next_r.blocked = |next_r.pend; // R11
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r.st <= pwr_pkg::ST_NORMAL; // R1
			r.cnt <= pwr_pkg::CNT_RESET;
			r.pend <= pwr_pkg::PEND_RESET;
			r.lxt_keep <= 1'b0;
			r.low_speed_internal_osc_keep <= 1'b0;
			r.resume <= 1'b0;
			r.sleep <= 1'b0;
			r.idle <= 1'b0;
			r.pd <= 1'b0;
			r.blocked <= 1'b0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Clock gating
	// On the wake path the core is gated in the clock-release state only; the oscillator-restart state leaves core_clk_en set
	assign gif.in_idle = (r.st == pwr_pkg::ST_IDLE) || (r.st == pwr_pkg::ST_CLK_RELEASE); // R22
	assign gif.in_pd = (r.st == pwr_pkg::ST_PD_ENTER) || (r.st == pwr_pkg::ST_POWERDOWN);
	assign gif.lxt_sw_on = r.lxt_keep;
	assign gif.low_speed_internal_osc_sw_on = r.low_speed_internal_osc_keep;
	assign gif.tmr_sel_low = tmr_sel_low;
	assign gif.wdt_sel_low_speed_internal_osc = wdt_sel_low_speed_internal_osc;
	assign gif.rtc_sel_lxt = rtc_sel_lxt;
	assign gif.uart_sel_lxt = uart_sel_lxt;

	pwr_clock_gates u_gates (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.g(gif),
		.hxt_en(hxt_en),
		.internal_fast_osc_en(internal_fast_osc_en),
		.internal_48m_osc_en(internal_48m_osc_en),
		.pll_en(pll_en),
		.lxt_en(lxt_en),
		.low_speed_internal_osc_en(low_speed_internal_osc_en),
		.core_clk_en(core_clk_en),
		.bus_clk_en(bus_clk_en),
		.flash_en(flash_en),
		.periph_en(periph_en),
		.ldo_en(ldo_en),
		.sram_ret_en(sram_ret_en),
		.timer_clk_en(timer_clk_en),
		.wdt_clk_en(wdt_clk_en),
		.rtc_clk_en(rtc_clk_en),
		.uart_clk_en(uart_clk_en)
	);

	// ==========================================================
	// Status outputs, all straight from state flops
	always_comb begin
		core_sleep = r.sleep;
		core_resume = r.resume;
		in_idle = r.idle;
		in_powerdown = r.pd;
		reentry_blocked = r.blocked;
		wake_cause = r.pend;
	end
endmodule
`default_nettype wire

// [verification/pwr_mode_asserts.sv]
// Purpose: Port-level checks of the power-mode controller
// Assumes: Core-side settings stay put while the core sleeps
// Notes: Gate enables lag the state by one cycle
`default_nettype none
module pwr_mode_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wfi,
	input wire logic sleep_en,
	input wire logic deep_sleep_request,
	input wire logic any_irq,
	input wire logic lxt_sw_on,
	input wire logic low_speed_internal_osc_sw_on,
	input wire logic wdt_sel_low_speed_internal_osc,
	input wire logic rtc_sel_lxt,
	input wire logic core_sleep,
	input wire logic core_resume,
	input wire logic in_idle,
	input wire logic in_powerdown,
	input wire logic reentry_blocked,
	input wire logic hxt_en,
	input wire logic pll_en,
	input wire logic lxt_en,
	input wire logic low_speed_internal_osc_en,
	input wire logic core_clk_en,
	input wire logic bus_clk_en,
	input wire logic periph_en,
	input wire logic ldo_en,
	input wire logic sram_ret_en,
	input wire logic wdt_clk_en,
	input wire logic rtc_clk_en
);
	// ==========================================================
	// Checks
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic go;
	assign go = ce && wfi && !core_sleep;
	sequence pd2;
		in_powerdown && $past(in_powerdown);
	endsequence
	a_reset_normal: assert property ($rose(rst_n) |-> !core_sleep && core_clk_en && hxt_en)
		else $error("not normal after reset");
	a_idle_entry: assert property (go && !deep_sleep_request && !any_irq |=> in_idle)
		else $error("idle not entered");
	a_idle_clocks: assert property (in_idle && $past(in_idle) |->
		!core_clk_en && bus_clk_en && hxt_en && pll_en)
		else $error("idle clocks wrong");
	a_idle_wake: assert property (ce && in_idle && any_irq |-> ##1 core_resume)
		else $error("idle did not wake");
	a_pd_entry: assert property (go && sleep_en && deep_sleep_request && !reentry_blocked
		|-> ##2 in_powerdown)
		else $error("power-down not entered");
	a_pd_halts: assert property (pd2 |->
		!(hxt_en || pll_en || bus_clk_en || periph_en) && ldo_en && sram_ret_en)
		else $error("power-down gates wrong");
	a_pd_low_osc: assert property (pd2 |-> lxt_en == lxt_sw_on && low_speed_internal_osc_en == low_speed_internal_osc_sw_on)
		else $error("low-speed oscillator wrong");
	a_pd_sel_clk: assert property (pd2 |-> wdt_clk_en == (wdt_sel_low_speed_internal_osc && low_speed_internal_osc_sw_on)
		&& rtc_clk_en == (rtc_sel_lxt && lxt_sw_on))
		else $error("kept clock wrong");
	a_resume_osc: assert property (core_resume |-> hxt_en && pll_en && !in_powerdown)
		else $error("resume before clocks");
	a_block_reentry: assert property (go && reentry_blocked |-> ##2 !in_powerdown)
		else $error("re-entry not blocked");
	cover property (in_idle ##1 core_resume);
	cover property (in_powerdown ##1 !in_powerdown);
	cover property (go && reentry_blocked);
endmodule
bind power_mode_wakeup_control pwr_mode_asserts pwr_mode_asserts_i (.*);
`default_nettype wire

// [verification/wake_peers.sv]
// Purpose: Wake-capable peripherals facing the controller
// Assumes: One source fires or clears at a time
// Notes: Source index order follows the controller wake causes
`default_nettype none
module wake_peers (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic clr,
	input wire logic [3:0] src,
	output logic [31:0] bod_ctl_flags,
	output logic [15:0] pin_irq_source_bits,
	output logic [1:0] timer_status,
	output logic [7:0] wdt_ctl_flags,
	output logic [1:0] rtc_status,
	output logic [4:0] uart_wake_status,
	output logic [16:0] universal_serial_unit_status,
	output logic [1:0] twowire_wake_status,
	output logic [9:0] analog_comparator_status
);
	logic [9:0] f;
	// Write-one clear drops the whole flag group, so paired flags fall together
	always_ff @(posedge clk) begin
		if (!rst_n)
			f <= 10'h000;
		else if (fire)
			f[src] <= 1'h1;
		else if (clr)
			f[src] <= 1'h0;
	end
	assign rtc_status = {1'h0, f[0]};
	assign wdt_ctl_flags = {2'h0, f[1], 5'h00};
	assign twowire_wake_status = {2{f[2]}};
	assign timer_status = {2{f[3]}};
	assign uart_wake_status = {f[4], 4'h0};
	assign universal_serial_unit_status = {f[5], 15'h0000, f[5]};
	assign bod_ctl_flags = {12'h000, f[7], 14'h0000, f[6], 4'h0};
	assign pin_irq_source_bits = {f[8], 15'h0000};
	assign analog_comparator_status = {f[9], f[9], 8'h00};
endmodule
`default_nettype wire

// [verification/power_mode_wakeup_control_bench.sv]
// Purpose: Directed run through idle and power-down for each wake source
// Assumes: Settle count shortened to 2 cycles
// Notes: Inputs change on the falling edge
`default_nettype none
module power_mode_wakeup_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, ce = 1, wfi = 0, sleep_en = 0, deep_sleep_request = 0, any_irq = 0;
	logic lxt_sw_on = 0, low_speed_internal_osc_sw_on = 0, tmr_sel_low = 0, wdt_sel_low_speed_internal_osc = 0;
	logic rtc_sel_lxt = 0, uart_sel_lxt = 0, fire = 0, clr = 0;
	logic [3:0] src = 4'h0;
	logic [31:0] bod_ctl_flags;
	logic [15:0] pin_irq_source_bits;
	logic [1:0] timer_status, rtc_status, twowire_wake_status;
	logic [7:0] wdt_ctl_flags;
	logic [4:0] uart_wake_status;
	logic [16:0] universal_serial_unit_status;
	logic [9:0] analog_comparator_status;
	logic core_sleep, core_resume, in_idle, in_powerdown, reentry_blocked, hxt_en, internal_fast_osc_en;
	logic internal_48m_osc_en, pll_en, lxt_en, low_speed_internal_osc_en, core_clk_en, bus_clk_en, flash_en, periph_en;
	logic ldo_en, sram_ret_en, timer_clk_en, wdt_clk_en, rtc_clk_en, uart_clk_en;
	logic [pwr_pkg::NUM_SRC-1:0] wake_cause;
	int fails = 0, n_checks = 0, cyc = 0;
	always #20 clk = ~clk;
	power_mode_wakeup_control #(.SETTLE_CYC(2)) power_mode_wakeup_control_i (.*);
	wake_peers wake_peers_i (.*);
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse_wfi;
		wfi = 1;
		tick(1);
		wfi = 0;
	endtask
	// Resume stands one cycle, so it is polled at every falling edge
	task automatic wait_resume;
		for (int k = 0; k < 100 && core_resume !== 1'h1; k++)
			tick(1);
		chk(core_resume, 1'h1);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim;
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		tick(4);
		rst_n = 1;
		tick(1);
		chk({core_sleep, in_idle, in_powerdown, reentry_blocked, hxt_en, core_clk_en}, 32'h03);
		pulse_wfi;
		chk(in_idle, 1'h1);
		tick(1);
		chk({core_clk_en, bus_clk_en, hxt_en, periph_en}, 32'h7);
		any_irq = 1;
		wait_resume;
		any_irq = 0;
		chk(in_idle, 1'h0);
		ce = 0;
		pulse_wfi;
		tick(1);
		chk({core_sleep, in_idle}, 32'h0);
		ce = 1;
		deep_sleep_request = 1;
		pulse_wfi;
		tick(2);
		chk({in_powerdown, in_idle, core_sleep}, 32'h0);
		sleep_en = 1;
		for (int i = 0; i < 10; i++) begin
			{lxt_sw_on, low_speed_internal_osc_sw_on} = {2{i[0]}};
			{tmr_sel_low, wdt_sel_low_speed_internal_osc, rtc_sel_lxt, uart_sel_lxt} = {4{i[1]}};
			pulse_wfi;
			tick(1);
			chk(in_powerdown, 1'h1);
			tick(1);
			chk({hxt_en, internal_fast_osc_en, internal_48m_osc_en, pll_en, core_clk_en, bus_clk_en, flash_en, periph_en,
				ldo_en, sram_ret_en}, 32'h003);
			chk({lxt_en, low_speed_internal_osc_en}, {2{i[0]}});
			chk({timer_clk_en, wdt_clk_en, rtc_clk_en, uart_clk_en}, {4{i[0] & i[1]}});
			src = 4'(i);
			fire = 1;
			tick(1);
			fire = 0;
			wait_resume;
			chk(hxt_en & pll_en, 1'h1);
			chk(wake_cause, 32'h1 << i);
			pulse_wfi;
			tick(2);
			chk(in_powerdown, 1'h0);
			clr = 1;
			tick(1);
			clr = 0;
			tick(1);
			chk(reentry_blocked, 1'h0);
		end
		end_sim;
	end
endmodule
`default_nettype wire
